/* File: hw/acg_clock_gate_select.sv */
// Bus-one peripheral clock source select and clock gate register with its enable outputs
//
// Functional notes
// - Control register at 0x30, read-write, resets to all zero so all gated.
// - Bit 24 picks ADC clock: zero analog block, one high-speed crystal.
// - Bits 23..20 pick PWM pair clocks: zero bus clock, one low-speed.
// - Bits 19:18 pick timer0: 00 bus, 01 low-speed, 1x external pin.
// - Bit 17 picks window watchdog: zero millisecond tick, one low-speed.
// - Bit 16 picks watchdog: zero low-speed, one millisecond tick.
// - Each enable bit stops its clock at zero, runs it at one.
// - Bit 8 gates the PWM bus-interface clock on its own.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module acg_clock_gate_select #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   // Source clock enables
   input wire acg_pkg::acg_src_t src,
   input wire logic first_timer_external_input,
   // Gated peripheral clock enables
   output acg_pkg::acg_gate_t gates
);

   // ****************************************
   // Register decode
   // ****************************************
   function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
      ctrl_hit = (a == ADDR_W'(acg_pkg::CTRL_OFF));
   endfunction

   logic [31:0] ctrl_q;
   logic [31:0] rdata_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ctrl_q <= acg_pkg::CTRL_RST;
      else if (wr_en && ctrl_hit(addr)) ctrl_q <= wdata & acg_pkg::CTRL_WMASK;
   end

   // Unmapped reads answer zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) rdata_q <= 32'h0000_0000;
      else if (rd_en && ctrl_hit(addr)) rdata_q <= ctrl_q;
      else rdata_q <= 32'h0000_0000;
   end

   assign rdata = rdata_q;

   // ****************************************
   // External timer pin conditioning
   // ****************************************
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic ext_lvl_q;
   logic ext_pulse_q;
   logic ext_agree;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= first_timer_external_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_agree = (ext_s2_q == ext_s3_q);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ext_lvl_q <= 1'b0;
      else if (ext_agree) ext_lvl_q <= ext_s2_q;
   end

   // One enable pulse per settled rising edge of the pin
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) ext_pulse_q <= 1'b0;
      else ext_pulse_q <= ext_agree && ext_s2_q && !ext_lvl_q;
   end

   // ****************************************
   // Source gating
   // ****************************************
   // Millisecond tick reaches the watchdogs only while its own enable is set
   logic milli_g;
   assign milli_g = src.milli && ctrl_q[acg_pkg::MILLI_EN];

   // ****************************************
   // Selected and gated kernel clocks
   // ****************************************
   logic adc_en;
   logic [3:0] pair_en;
   logic tmr_en;
   logic wwdt_en;
   logic wdt_en;

   acg_clk_slot #(.NSRC(2), .SW(1)) u_adc (
      .clock(clock),
      .rst_n(rst_n),
      .src_en({src.high, src.analog}),
      .sel(ctrl_q[acg_pkg::ADC_SEL]),
      .gate(ctrl_q[acg_pkg::ADC_GATE]),
      .clk_en(adc_en)
   );

   // Bus clock is always running, so its enable is a constant one
   for (genvar i = 0; i < acg_pkg::PAIR_CNT; i++) begin : g_pair
      acg_clk_slot #(.NSRC(2), .SW(1)) u_pair (
         .clock(clock),
         .rst_n(rst_n),
         .src_en({src.low, 1'b1}),
         .sel(ctrl_q[acg_pkg::PAIR01_SEL + i]),
         .gate(ctrl_q[acg_pkg::PAIR01_GATE + i]),
         .clk_en(pair_en[i])
      );
   end

   acg_clk_slot #(.NSRC(4), .SW(2)) u_tmr (
      .clock(clock),
      .rst_n(rst_n),
      .src_en({ext_pulse_q, ext_pulse_q, src.low, 1'b1}),
      .sel(ctrl_q[acg_pkg::TMR_SEL_HI:acg_pkg::TMR_SEL_LO]),
      .gate(ctrl_q[acg_pkg::TMR_GATE]),
      .clk_en(tmr_en)
   );

   acg_clk_slot #(.NSRC(2), .SW(1)) u_wwdt (
      .clock(clock),
      .rst_n(rst_n),
      .src_en({src.low, milli_g}),
      .sel(ctrl_q[acg_pkg::WWDT_SEL]),
      .gate(ctrl_q[acg_pkg::WWDT_GATE]),
      .clk_en(wwdt_en)
   );

   acg_clk_slot #(.NSRC(2), .SW(1)) u_wdt (
      .clock(clock),
      .rst_n(rst_n),
      .src_en({milli_g, src.low}),
      .sel(ctrl_q[acg_pkg::WDT_SEL]),
      .gate(ctrl_q[acg_pkg::WDT_GATE]),
      .clk_en(wdt_en)
   );

   // ****************************************
   // Output assembly
   // ****************************************
   // Bus-clocked gates are register bits, already flops
   always_comb begin
      gates.adc = adc_en;
      gates.pair = pair_en;
      gates.timer = tmr_en;
      gates.wwdt = wwdt_en;
      gates.wdt = wdt_en;
      gates.pwm_bus = ctrl_q[acg_pkg::PBUS_GATE];
      gates.uart = ctrl_q[acg_pkg::UART_GATE];
      gates.spi = ctrl_q[acg_pkg::SPI_GATE];
      gates.i2c = ctrl_q[acg_pkg::I2C_GATE];
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   property p_write_lands;
      wr_en && ctrl_hit(addr) |=> ctrl_q == ($past(wdata) & acg_pkg::CTRL_WMASK);
   endproperty
   a_write_lands: assert property (p_write_lands)
      else $error("control write not stored");

   property p_read_back;
      rd_en |=> rdata == ($past(ctrl_hit(addr)) ? $past(ctrl_q) : 32'h0000_0000);
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read data wrong");

   property p_reserved_zero;
      (ctrl_q & ~acg_pkg::CTRL_WMASK) == 32'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_adc_src;
      gates.adc |-> ($past(ctrl_q[acg_pkg::ADC_SEL]) ? $past(src.high) : $past(src.analog));
   endproperty
   a_adc_src: assert property (p_adc_src)
      else $error("adc enable from wrong source");

   property p_pair_src;
      gates.pair[0] && $past(ctrl_q[acg_pkg::PAIR01_SEL]) |-> $past(src.low);
   endproperty
   a_pair_src: assert property (p_pair_src)
      else $error("pair clock from wrong source");

   property p_tmr_src;
      gates.timer |-> ($past(ctrl_q[acg_pkg::TMR_SEL_HI]) ? $past(ext_pulse_q) :
         ($past(ctrl_q[acg_pkg::TMR_SEL_LO]) ? $past(src.low) : 1'b1));
   endproperty
   a_tmr_src: assert property (p_tmr_src)
      else $error("timer enable from wrong source");

   property p_wwdt_src;
      gates.wwdt |-> ($past(ctrl_q[acg_pkg::WWDT_SEL]) ? $past(src.low) : $past(milli_g));
   endproperty
   a_wwdt_src: assert property (p_wwdt_src)
      else $error("window watchdog enable from wrong source");

   property p_wdt_src;
      gates.wdt |-> ($past(ctrl_q[acg_pkg::WDT_SEL]) ? $past(milli_g) : $past(src.low));
   endproperty
   a_wdt_src: assert property (p_wdt_src)
      else $error("watchdog enable from wrong source");

   property p_gate_off;
      !ctrl_q[acg_pkg::TMR_GATE] |=> !gates.timer;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("timer clock runs while gated");

   property p_pbus_gate;
      wr_en && ctrl_hit(addr) |=> gates.pwm_bus == $past(wdata[acg_pkg::PBUS_GATE]);
   endproperty
   a_pbus_gate: assert property (p_pbus_gate)
      else $error("pwm bus gate not following write");

   property p_switch_quiet;
      $changed(ctrl_q[acg_pkg::TMR_SEL_HI:acg_pkg::TMR_SEL_LO]) |-> ##1 !gates.timer [*2];
   endproperty
   a_switch_quiet: assert property (p_switch_quiet)
      else $error("timer enable leaked across a source switch");

   property p_gate_quiet;
      $rose(ctrl_q[acg_pkg::ADC_GATE]) |-> ##1 !gates.adc [*2];
   endproperty
   a_gate_quiet: assert property (p_gate_quiet)
      else $error("adc enable came out as a runt");

   property p_rdata_idle;
      !rd_en |=> rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data left standing without a read");

   property p_serial_gates;
      wr_en && ctrl_hit(addr) |=> gates.uart == $past(wdata[acg_pkg::UART_GATE]) &&
         gates.spi == $past(wdata[acg_pkg::SPI_GATE]) && gates.i2c == $past(wdata[acg_pkg::I2C_GATE]);
   endproperty
   a_serial_gates: assert property (p_serial_gates)
      else $error("serial gates not following write");

   property p_pair67_src;
      gates.pair[3] && $past(ctrl_q[acg_pkg::PAIR01_SEL + 3]) |-> $past(src.low);
   endproperty
   a_pair67_src: assert property (p_pair67_src)
      else $error("upper pair clock from wrong source");

   property p_milli_gate;
      gates.wdt && $past(ctrl_q[acg_pkg::WDT_SEL]) |-> $past(ctrl_q[acg_pkg::MILLI_EN]);
   endproperty
   a_milli_gate: assert property (p_milli_gate)
      else $error("watchdog ticked from a disabled millisecond source");

   property p_adc_off;
      !ctrl_q[acg_pkg::ADC_GATE] |=> !gates.adc;
   endproperty
   a_adc_off: assert property (p_adc_off)
      else $error("adc clock runs while gated");

   property p_pair_off;
      !ctrl_q[acg_pkg::PAIR01_GATE] |=> !gates.pair[0];
   endproperty
   a_pair_off: assert property (p_pair_off)
      else $error("pair clock runs while gated");

   property p_wwdt_off;
      !ctrl_q[acg_pkg::WWDT_GATE] |=> !gates.wwdt;
   endproperty
   a_wwdt_off: assert property (p_wwdt_off)
      else $error("window watchdog clock runs while gated");

   property p_wdt_off;
      !ctrl_q[acg_pkg::WDT_GATE] |=> !gates.wdt;
   endproperty
   a_wdt_off: assert property (p_wdt_off)
      else $error("watchdog clock runs while gated");

   property p_ext_single;
      ext_pulse_q |=> !ext_pulse_q;
   endproperty
   a_ext_single: assert property (p_ext_single)
      else $error("external timer pulse stretched");

   c_tmr_ext: cover property (gates.timer && ctrl_q[acg_pkg::TMR_SEL_HI]);
   c_adc_high: cover property (gates.adc && ctrl_q[acg_pkg::ADC_SEL]);
   c_wdt_milli: cover property (gates.wdt && ctrl_q[acg_pkg::WDT_SEL]);
   c_pair_switch: cover property ($changed(ctrl_q[acg_pkg::PAIR01_SEL]) && ctrl_q[acg_pkg::PAIR01_GATE]);

endmodule // acg_clock_gate_select

/* File: hw/acg_pkg.sv */
// Constants and carrier types for the bus-one peripheral clock select and gate block
package acg_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CTRL_OFF = 8'h30;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // Writable bits; 31:25, 15:14 and 2 stay zero
   localparam logic [31:0] CTRL_WMASK = 32'h01ff_3ffb;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ADC_SEL = 24;
   localparam int PAIR01_SEL = 20;
   localparam int TMR_SEL_HI = 19;
   localparam int TMR_SEL_LO = 18;
   localparam int WWDT_SEL = 17;
   localparam int WDT_SEL = 16;
   localparam int MILLI_EN = 13;
   localparam int TMR_GATE = 12;
   localparam int WWDT_GATE = 11;
   localparam int WDT_GATE = 10;
   localparam int ADC_GATE = 9;
   localparam int PBUS_GATE = 8;
   localparam int PAIR01_GATE = 4;
   localparam int UART_GATE = 3;
   localparam int SPI_GATE = 1;
   localparam int I2C_GATE = 0;
   localparam int PAIR_CNT = 4;

   // ****************************************
   // Source codes
   // ****************************************
   localparam logic [1:0] TMR_SRC_BUS = 2'h0;
   localparam logic [1:0] TMR_SRC_LOW = 2'h1;

   // ****************************************
   // Carriers
   // ****************************************
   // Source clocks as one-cycle enable pulses on the bus clock
   typedef struct packed {
      logic analog;
      logic high;
      logic low;
      logic milli;
   } acg_src_t;

   // Gated clock enables handed to the peripherals
   typedef struct packed {
      logic adc;
      logic [3:0] pair;
      logic timer;
      logic wwdt;
      logic wdt;
      logic pwm_bus;
      logic uart;
      logic spi;
      logic i2c;
   } acg_gate_t;

endpackage

/* File: hw/acg_clk_slot.sv */
// One selectable, gated clock enable with a clean hand-over between sources
`timescale 1ns/10ps
module acg_clk_slot #(
   parameter int NSRC = 2,
   parameter int SW = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Sources and control
   input wire logic [NSRC-1:0] src_en,
   input wire logic [SW-1:0] sel,
   input wire logic gate,
   // Gated enable
   output logic clk_en
);

   // ****************************************
   // Hand-over state
   // ****************************************
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN = 3'b100
   } acg_slot_st_t;

   acg_slot_st_t st_q;
   acg_slot_st_t st_d;
   logic [SW-1:0] sel_q;
   logic chg;
   logic pick;

   assign chg = (sel != sel_q);
   assign pick = src_en[sel];

   // Waiting for a fresh pulse of the new source drops any partial period
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_OFF: begin
            if (gate) st_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (!gate) st_d = ST_OFF;
            else if (!chg && pick) st_d = ST_RUN;
         end
         ST_RUN: begin
            if (!gate) st_d = ST_OFF;
            else if (chg) st_d = ST_WAIT;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) st_q <= ST_OFF;
      else st_q <= st_d;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) sel_q <= '0;
      else sel_q <= sel;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) clk_en <= 1'b0;
      else clk_en <= (st_q == ST_RUN) && gate && !chg && pick;
   end

endmodule // acg_clk_slot

/* File: dv/acg_periph_model.sv */
// Peripheral-side model counting the clock enables it receives
`timescale 1ns/10ps
module acg_periph_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Gated enables and count control
   input wire acg_pkg::acg_gate_t gates,
   input wire logic clr,
   output logic [7:0] cnt [12]
);
   // ****************************************
   // Tick counters
   // ****************************************
   // Counts every enabled cycle, so a stretched pulse shows as an extra tick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '{default: 8'h00};
      end else begin
         for (int i = 0; i < 12; i++) begin
            cnt[i] <= clr ? 8'h00 : cnt[i] + {7'h00, gates[i]};
         end
      end
   end
endmodule // acg_periph_model

/* File: dv/acg_clock_gate_select_test.sv */
// Self-checking bench for the bus-one clock select and gate block
`timescale 1ns/10ps
module acg_clock_gate_select_test;
   logic clock;
   logic rst_n;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr_en;
   logic rd_en;
   logic [31:0] rdata;
   acg_pkg::acg_src_t src;
   logic ext_pin;
   acg_pkg::acg_gate_t gates;
   logic clr;
   logic [7:0] cnt [12];
   int n_mismatch;
   int tests_run;
   int k;
   // Case table: select word, gate bit, right source, wrong source, output bit
   logic [31:0] c_sel [11] = '{32'h0, 32'h0100_0000, 32'h0010_0000, 32'h0080_0000, 32'h0004_0000,
      32'h0008_0000, 32'h000c_0000, 32'h0000_2000, 32'h0002_2000, 32'h0000_2000, 32'h0001_2000};
   int c_gate [11] = '{9, 9, 4, 7, 12, 12, 12, 11, 11, 10, 10};
   int c_ok [11] = '{0, 1, 2, 2, 2, 4, 4, 3, 2, 2, 3};
   int c_bad [11] = '{1, 0, 3, 0, 4, 2, 2, 2, 3, 3, 2};
   int c_out [11] = '{11, 11, 7, 10, 6, 6, 6, 5, 5, 4, 4};

   acg_clock_gate_select #(.ADDR_W(8)) i_acg_clock_gate_select (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src(src),
      .first_timer_external_input(ext_pin), .gates(gates));
   acg_periph_model i_acg_periph_model (.clock(clock), .rst_n(rst_n), .gates(gates), .clr(clr), .cnt(cnt));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic clrcnt;
      @(posedge clock);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
   endtask

   // Sources 0..3 pulse one cycle; 4 is the slow external pin
   task automatic pulse4(input int s);
      repeat (4) begin
         @(posedge clock);
         if (s == 4) begin
            ext_pin <= 1'b1;
         end else begin
            src <= acg_pkg::acg_src_t'(4'h8 >> s);
         end
         @(posedge clock);
         src <= '0;
         repeat (3) @(posedge clock);
         ext_pin <= 1'b0;
         repeat (4) @(posedge clock);
      end
      #1;
   endtask

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Run is about 1350 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      src = '0;
      ext_pin = 1'b0;
      clr = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rdc(8'h30, 32'h0);
      wr(8'h30, 32'hffff_ffff);
      rdc(8'h30, 32'h01ff_3ffb);
      @(posedge clock);
      #1;
      chk(rdata, 32'h0000_0000);
      chk({28'h0, gates[3:0]}, 32'hf);
      wr(8'h34, 32'h0);
      rdc(8'h30, 32'h01ff_3ffb);
      rdc(8'h34, 32'h0);
      wr(8'h30, 32'h0);
      #1;
      chk({28'h0, gates[3:0]}, 32'h0);
      // Bus-interface gate alone leaves the serial gates shut
      wr(8'h30, 32'h0000_0100);
      #1;
      chk({28'h0, gates[3:0]}, 32'h8);
      // Bus source for pairs 2/3, 4/5 and timer code 00 runs every cycle once enabled
      wr(8'h30, 32'h0000_1060);
      repeat (3) @(posedge clock);
      clrcnt();
      repeat (8) @(posedge clock);
      #1;
      chk({24'h0, cnt[8]}, 32'h8);
      chk({24'h0, cnt[9]}, 32'h8);
      chk({24'h0, cnt[6]}, 32'h8);
      for (k = 0; k < 11; k++) begin
         wr(8'h30, c_sel[k]);
         wr(8'h30, c_sel[k] | (32'h1 << c_gate[k]));
         clrcnt();
         pulse4(c_bad[k]);
         chk({24'h0, cnt[c_out[k]]}, 32'h0);
         pulse4(c_ok[k]);
         // First pulse after enable is dropped for a clean start
         chk({24'h0, cnt[c_out[k]]}, 32'h3);
         wr(8'h30, c_sel[k]);
         clrcnt();
         pulse4(c_ok[k]);
         chk({24'h0, cnt[c_out[k]]}, 32'h0);
      end
      end_of_test();
   end
endmodule // acg_clock_gate_select_test
